// *** logic/rfeu_map.vh ***
// Constants for the rotate, flag and return execution unit.
// Assumes inclusion by the execution unit only; definitions only.
`ifndef RFEU_MAP_VH
`define RFEU_MAP_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define RFEU_OP_CLEAR_CARRY   8'hcf
`define RFEU_OP_SUB_EXIT      8'haf
`define RFEU_OP_ROT_LEFT      8'h90
`define RFEU_OP_ROT_LEFT_C    8'h10
`define RFEU_OP_ROT_RIGHT     8'he0
`define RFEU_OP_ROT_RIGHT_C   8'hc0
`define RFEU_OP_BANK_ZERO     8'h4f
// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define RFEU_FLAG_C           7
`define RFEU_FLAG_Z           6
`define RFEU_FLAG_S           5
`define RFEU_FLAG_V           4
`define RFEU_FLAG_D           3
`define RFEU_FLAG_H           2
`define RFEU_FLAG_BANK        0
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define RFEU_FLAGS_RESET      8'h00
`define RFEU_SP_RESET         16'h0000
`define RFEU_PC_RESET         16'h0000
`define RFEU_CYC_SHORT        4'h4
`define RFEU_CYC_EXIT_INT     4'h8
`define RFEU_CYC_EXIT_EXT     4'ha
`endif

// *** logic/rfeu_exec_unit.v ***
// Execution unit for rotates, carry clear, bank select and subroutine exit.
// Assumes a register file that answers while its registered address stands and a
// stack memory whose read data comes a cycle after the strobe; both are outside this module.
`timescale 1ns/10ps
`include "rfeu_map.vh"
module rfeu_exec_unit #(
   parameter EXT_STACK = 0
) (
   // Clock and reset.
   input  wire        clock,
   input  wire        rst_n,
   // Instruction issue.
   input  wire        issueValid,
   input  wire [7:0]  issueOpcode,
   input  wire [7:0]  issueOperand,
   output reg         busy_reg,
   output reg         done_reg,
   output reg         fetchReq_reg,
   // Register file port.
   output reg  [7:0]  rfAddr_reg,
   output reg         rfRead_reg,
   output reg         rfWrite_reg,
   output reg  [7:0]  rfWdata_reg,
   input  wire [7:0]  rfRdata,
   // Stack memory port.
   output reg  [15:0] stackAddr_reg,
   output reg         stackRead_reg,
   input  wire [7:0]  stackRdata,
   // Architectural state.
   output reg  [7:0]  flags_reg,
   output reg  [15:0] pc_reg,
   output reg  [15:0] sp_reg
);

   // ----------------------------------------
   // State encoding
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_IND  = 3'h1;
   localparam [2:0] ST_OPER = 3'h2;
   localparam [2:0] ST_HIGH = 3'h3;
   localparam [2:0] ST_LOW  = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;
   localparam [2:0] ST_PCLO = 3'h6;
   // Exit walks ST_HIGH, ST_LOW and ST_PCLO, one stack byte a cycle, then waits.

   // Working registers of the sequencer and the combinational rotate path.
   reg [2:0]  state_reg;
   reg [3:0]  cycLeft_reg;
   reg [7:0]  op_reg;
   reg [7:0]  rotRes;
   reg        rotCarry;
   reg        isRot;

   // ----------------------------------------
   // Rotate datapath
   // ----------------------------------------
   // Rotate result and carry out, from the operand and the old carry.
   // The operand is the read data of the ST_OPER cycle, so the overflow
   // compare below still sees the sign bit from before the rotation.
   always @* begin
      rotRes   = rfRdata;
      rotCarry = flags_reg[`RFEU_FLAG_C];
      isRot    = 1'b1;
      case ({op_reg[7:1], 1'b0})
         `RFEU_OP_ROT_LEFT: begin
            rotRes   = {rfRdata[6:0], rfRdata[7]};
            rotCarry = rfRdata[7];
         end
         `RFEU_OP_ROT_LEFT_C: begin
            rotRes   = {rfRdata[6:0], flags_reg[`RFEU_FLAG_C]};
            rotCarry = rfRdata[7];
         end
         `RFEU_OP_ROT_RIGHT: begin
            rotRes   = {rfRdata[0], rfRdata[7:1]};
            rotCarry = rfRdata[0];
         end
         `RFEU_OP_ROT_RIGHT_C: begin
            rotRes   = {flags_reg[`RFEU_FLAG_C], rfRdata[7:1]};
            rotCarry = rfRdata[0];
         end
         default: isRot = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Every instruction runs its full documented cycle count so the fetch
   // timing seen by the core matches the instruction table, even though the
   // datapath work finishes earlier.
   // The register file answers while its registered address stands; the
   // stack answers one cycle after its registered read strobe.
   always @(posedge clock) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         cycLeft_reg   <= 4'h0;
         op_reg        <= 8'h00;
         busy_reg      <= 1'b0;
         done_reg      <= 1'b0;
         fetchReq_reg  <= 1'b0;
         rfAddr_reg    <= 8'h00;
         rfRead_reg    <= 1'b0;
         rfWrite_reg   <= 1'b0;
         rfWdata_reg   <= 8'h00;
         stackAddr_reg <= 16'h0000;
         stackRead_reg <= 1'b0;
         flags_reg     <= `RFEU_FLAGS_RESET;
         pc_reg        <= `RFEU_PC_RESET;
         sp_reg        <= `RFEU_SP_RESET;
      end else begin
         done_reg      <= 1'b0;
         fetchReq_reg  <= 1'b0;
         rfRead_reg    <= 1'b0;
         rfWrite_reg   <= 1'b0;
         stackRead_reg <= 1'b0;
         // The count runs down in every busy state, so each path ends on its
         // documented cycle whatever states it happens to visit.
         if (state_reg != ST_IDLE && cycLeft_reg != 4'h0) begin
            cycLeft_reg <= cycLeft_reg - 4'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (issueValid) begin
                  op_reg   <= issueOpcode;
                  busy_reg <= 1'b1;
                  case (issueOpcode)
                     `RFEU_OP_CLEAR_CARRY: begin
                        // Only the carry bit is touched; every other flag keeps its value.
                        flags_reg[`RFEU_FLAG_C] <= 1'b0;
                        cycLeft_reg <= `RFEU_CYC_SHORT - 4'h2;
                        state_reg   <= ST_WAIT;
                     end
                     `RFEU_OP_BANK_ZERO: begin
                        // Bank bit only; the arithmetic flags stay as they are.
                        flags_reg[`RFEU_FLAG_BANK] <= 1'b0;
                        cycLeft_reg <= `RFEU_CYC_SHORT - 4'h2;
                        state_reg   <= ST_WAIT;
                     end
                     `RFEU_OP_SUB_EXIT: begin
                        // First stack read goes out now; extra external cycles are padding.
                        stackAddr_reg <= sp_reg;
                        stackRead_reg <= 1'b1;
                        cycLeft_reg   <= (EXT_STACK != 0) ? `RFEU_CYC_EXIT_EXT - 4'h2
                                                          : `RFEU_CYC_EXIT_INT - 4'h2;
                        state_reg     <= ST_HIGH;
                     end
                     default: begin
                        // Rotates: odd opcode means indirect operand.
                        // Unknown opcodes take the same path but never write,
                        // so they behave as four-cycle no-ops.
                        rfAddr_reg  <= issueOperand;
                        rfRead_reg  <= 1'b1;
                        cycLeft_reg <= `RFEU_CYC_SHORT - 4'h2;
                        state_reg   <= issueOpcode[0] ? ST_IND : ST_OPER;
                     end
                  endcase
               end
            end
            ST_IND: begin
               // The pointer register holds the operand's address.
               rfAddr_reg <= rfRdata;
               rfRead_reg <= 1'b1;
               state_reg  <= ST_OPER;
            end
            ST_OPER: begin
               if (isRot) begin
                  rfWdata_reg <= rotRes;
                  rfWrite_reg <= 1'b1;
                  flags_reg[`RFEU_FLAG_C] <= rotCarry;
                  flags_reg[`RFEU_FLAG_Z] <= (rotRes == 8'h00);
                  flags_reg[`RFEU_FLAG_S] <= rotRes[7];
                  // Sign change of the operand; D and H are left alone.
                  flags_reg[`RFEU_FLAG_V] <= rotRes[7] ^ rfRdata[7];
               end
               state_reg <= ST_WAIT;
            end
            ST_HIGH: begin
               stackAddr_reg <= sp_reg + 16'h0001;
               stackRead_reg <= 1'b1;
               state_reg     <= ST_LOW;
            end
            ST_LOW: begin
               // The byte at the lower stack address lands in the high half
               // of the program counter; the pointer moves past both bytes.
               pc_reg[15:8] <= stackRdata;
               sp_reg       <= sp_reg + 16'h0002;
               state_reg    <= ST_PCLO;
            end
            ST_PCLO: begin
               // The byte one above arrives a cycle later and fills the low half.
               pc_reg[7:0] <= stackRdata;
               state_reg   <= ST_WAIT;
            end
            ST_WAIT: begin
               // Pad to the documented count; the fetch request is raised only
               // once the new program counter is already in place.
               if (cycLeft_reg == 4'h0) begin
                  state_reg    <= ST_IDLE;
                  busy_reg     <= 1'b0;
                  done_reg     <= 1'b1;
                  fetchReq_reg <= 1'b1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule

// *** dv/rfeu_mem_model.sv ***
// Register file and stack memory that sit beside the execution unit.
// Assumes register file reads are answered at once and stack reads one cycle later; the stack keeps 256 bytes.
`timescale 1ns/10ps
module rfeu_mem_model (
   // Clock.
   input  wire        clock,
   // Register file side.
   input  wire [7:0]  rfAddr_reg,
   input  wire        rfRead_reg,
   input  wire        rfWrite_reg,
   input  wire [7:0]  rfWdata_reg,
   output reg  [7:0]  rfRdata,
   // Stack side.
   input  wire [15:0] stackAddr_reg,
   input  wire        stackRead_reg,
   output reg  [7:0]  stackRdata
);
   reg [7:0] rf [0:255];
   reg [7:0] stk [0:255];
   initial begin
      stackRdata = 8'h00;
   end
   // The register file answers while its registered address stands, as the
   // unit samples at the next edge; with no read pending it shows the
   // inverse of the addressed word, so a stray sample never passes.
   always @* begin
      rfRdata = rfRead_reg ? rf[rfAddr_reg] : ~rf[rfAddr_reg];
   end
   // The stack answers one cycle after its read strobe; idle lines toggle.
   always @(posedge clock) begin
      stackRdata <= stackRead_reg ? stk[stackAddr_reg[7:0]] : ~stackRdata;
      if (rfWrite_reg) begin
         rf[rfAddr_reg] <= rfWdata_reg;
      end
   end
endmodule

// *** dv/rfeu_exec_sva.sv ***
// Timing checker for the execution unit.
// Assumes it is bound to rfeu_exec_unit and sees only its ports.
`timescale 1ns/10ps
module rfeu_exec_sva #(parameter EXT_STACK = 0) (
   // Clock, reset and issue.
   input wire        clock,
   input wire        rst_n,
   input wire        issueValid,
   input wire [7:0]  issueOpcode,
   input wire [7:0]  issueOperand,
   // Outputs watched.
   input wire        busy_reg,
   input wire        done_reg,
   input wire        fetchReq_reg,
   input wire [7:0]  rfAddr_reg,
   input wire        rfRead_reg,
   input wire [15:0] stackAddr_reg,
   input wire        stackRead_reg,
   input wire [7:0]  flags_reg,
   input wire [15:0] sp_reg
);
   localparam int EX = EXT_STACK ? 10 : 8;
   // An issue counts only while idle; a busy unit drops it.
   wire taken = issueValid && !busy_reg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_done_four: assert property (taken && issueOpcode != 8'haf |-> ##4 done_reg)
      else $error("short op end late");
   chk_exit_cycles: assert property (taken && issueOpcode == 8'haf |-> ##EX done_reg)
      else $error("exit end late");
   chk_fetch_pair: assert property (done_reg == fetchReq_reg)
      else $error("fetch not with done");
   chk_carry_clear: assert property (taken && issueOpcode == 8'hcf |-> ##4 flags_reg == ($past(flags_reg, 4) & 8'h7f))
      else $error("carry clear wrong");
   chk_bank_zero: assert property (taken && issueOpcode == 8'h4f |-> ##4 flags_reg == ($past(flags_reg, 4) & 8'hfe))
      else $error("bank clear wrong");
   chk_exit_stack: assert property (taken && issueOpcode == 8'haf |-> ##1 (stackRead_reg && stackAddr_reg == $past(sp_reg))
      ##1 (stackRead_reg && stackAddr_reg == $past(sp_reg, 2) + 16'h0001)) else $error("stack reads wrong");
   chk_exit_sp: assert property (taken && issueOpcode == 8'haf |-> ##EX (sp_reg == $past(sp_reg, EX) + 16'h0002
      && flags_reg == $past(flags_reg, EX))) else $error("exit sp or flags wrong");
   chk_rot_read: assert property (taken && issueOpcode inside {8'h90, 8'h10, 8'he0, 8'hc0}
      |-> ##1 rfRead_reg && rfAddr_reg == $past(issueOperand)) else $error("operand read wrong");
   chk_busy_hold: assert property (taken |-> ##1 busy_reg [*3])
      else $error("busy dropped early");
   cover property (taken && issueOpcode == 8'haf);
   cover property (taken && issueOpcode == 8'hcf);
   cover property (taken && issueOpcode == 8'h91);
endmodule
bind rfeu_exec_unit rfeu_exec_sva #(.EXT_STACK(EXT_STACK)) rfeu_exec_sva_inst (.*);

// *** dv/rfeu_exec_unit_bench.sv ***
// Self-checking bench for the execution unit.
// Assumes the memory model is preloaded through its arrays.
`timescale 1ns/10ps
module rfeu_exec_unit_bench;
   reg         clock = 1'b0;
   reg         rst_n = 1'b0;
   reg         issueValid = 1'b0;
   reg  [7:0]  issueOpcode = 8'h00;
   reg  [7:0]  issueOperand = 8'h00;
   wire        busy_reg, done_reg, fetchReq_reg, rfRead_reg, rfWrite_reg, stackRead_reg;
   wire [7:0]  rfAddr_reg, rfWdata_reg, rfRdata, stackRdata, flags_reg;
   wire [15:0] stackAddr_reg, pc_reg, sp_reg;
   integer     failures = 0, checks = 0, i, n;
   reg  [7:0]  expF, v, res, op, a;
   reg         nc;
   localparam [63:0] VALS = 64'haa31_5500_01fe_8155;
   rfeu_exec_unit #(.EXT_STACK(0)) rfeu_exec_unit_inst (.*);
   rfeu_mem_model rfeu_mem_model_inst (.*);
   initial begin
      forever #5 clock = ~clock;
   end
   // Every result is widened to 16 bits so one compare serves all.
   task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("mismatch %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // Issue one op and count cycles to completion, bounded.
   task run(input [7:0] o, input [7:0] r, input integer cyc);
      begin
         @(negedge clock);
         issueValid = 1'b1;
         issueOpcode = o;
         issueOperand = r;
         @(negedge clock);
         issueValid = 1'b0;
         n = 1;
         while (done_reg !== 1'b1 && n < 20) begin
            @(negedge clock);
            n = n + 1;
         end
         chk("cycles", cyc[15:0], n[15:0]);
         chk("fetch", 16'h0001, {15'h0000, fetchReq_reg});
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      for (i = 0; i < 8; i = i + 1) begin
         rfeu_mem_model_inst.rf[i] = 8'h40 + i[7:0];
         rfeu_mem_model_inst.stk[i] = 8'h10 + 8'h0a * i[7:0];
      end
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      chk("flags", 16'h0000, {8'h00, flags_reg});
      chk("sp", 16'h0000, sp_reg);
      expF = 8'h00;
      // Each rotate in direct, then indirect form, with carry carried on.
      for (i = 0; i < 8; i = i + 1) begin
         op = ((i / 2 == 0) ? 8'h90 : (i / 2 == 1) ? 8'h10 : (i / 2 == 2) ? 8'he0 : 8'hc0) | i[0];
         v = VALS[63 - 8 * i -: 8];
         a = i[0] ? 8'h40 + i[7:0] : 8'h10 + i[7:0];
         rfeu_mem_model_inst.rf[a] = v;
         case (op & 8'hfe)
            8'h90: {nc, res} = {v[7], v[6:0], v[7]};
            8'h10: {nc, res} = {v[7], v[6:0], expF[7]};
            8'he0: {nc, res} = {v[0], v[0], v[7:1]};
            default: {nc, res} = {v[0], expF[7], v[7:1]};
         endcase
         expF = {nc, res == 8'h00, res[7], res[7] ^ v[7], expF[3:0]};
         run(op, i[0] ? i[7:0] : a, 4);
         chk("result", {8'h00, res}, {8'h00, rfeu_mem_model_inst.rf[a]});
         chk("flags", {8'h00, expF}, {8'h00, flags_reg});
      end
      run(8'hcf, 8'h00, 4);
      chk("flags", {8'h00, expF & 8'h7f}, {8'h00, flags_reg});
      run(8'h4f, 8'h00, 4);
      chk("flags", {8'h00, expF & 8'h7e}, {8'h00, flags_reg});
      for (i = 0; i < 2; i = i + 1) begin
         run(8'haf, 8'h00, 8);
         // Preloaded stack bytes 10,1a then 24,2e give the two return addresses.
         chk("pc", i[0] ? 16'h242e : 16'h101a, pc_reg);
         chk("sp", {14'h0000, i[0], 1'b0} + 16'h0002, sp_reg);
      end
      end_of_test;
   end
   initial begin
      #100000;
      failures = failures + 1;
      end_of_test;
   end
endmodule
